// ===== hdl/ssac_ctrl.sv
// Purpose: synchronous access control of a flow-through burst SRAM
// Assumes: inputs synchronous to i_ref_clk; memory core outside this block
// Notes:   output enable acts on the data pins without a clock edge
//
// Overview of operation
// - processor strobe while selected starts a read, writes ignored
// - writes only on controller strobe or in burst cycles after a selected strobe
// - once a write starts, output enable is ignored for that cycle
// - output enable is asynchronous, never registered on the clock
// - during writes output enable is masked, data pins stay undriven
// - read: pins undriven while output enable high or chip deselected
// - read with chip selected and output enable low drives read data
// - lane write a alone writes byte 0, lane a plus parity
// - lane write b alone writes byte 1, lane b plus parity
// - two-bit burst counter wraps in four, steps on burst advance low
// - burst mode picks interleaved (xor) or linear (add) order
// - sleep takes two cycles in and out; master keeps bus idle
`timescale 1ns/1ps
`include "ssac_defines.svh"

module ssac_ctrl
	import ssac_pkg::*;
(
	// clock and reset
	input  wire logic                      i_ref_clk,
	input  wire logic                      i_rst,
	// selects and strobes
	input  wire logic                      i_chip_select_one_n,
	input  wire logic                      i_chip_select_two,
	input  wire logic                      i_chip_select_three_n,
	input  wire logic                      i_processor_address_strobe_n,
	input  wire logic                      i_controller_address_strobe_n,
	input  wire logic                      i_burst_advance_n,
	input  wire logic                      i_burst_mode,
	input  wire logic                      i_sleep_request,
	// write controls
	input  wire logic                      i_global_write_n,
	input  wire logic                      i_byte_write_gate_n,
	input  wire logic                      i_lane_write_a_n,
	input  wire logic                      i_lane_write_b_n,
	// output enable, asynchronous
	input  wire logic                      i_output_enable_n,
	// address and data pins
	input  wire logic [`SSAC_ADDR_W-1:0]   i_addr,
	input  wire logic [`SSAC_DATA_W-1:0]   i_data_pins,
	output logic      [`SSAC_DATA_W-1:0]   o_data_pins,
	output logic                           o_data_pins_oe,
	// memory core side
	input  wire logic [`SSAC_DATA_W-1:0]   i_core_rdata,
	output logic      [`SSAC_ADDR_W-1:0]   o_core_addr,
	output logic      [`SSAC_LANES-1:0]    o_core_lane_we,
	output logic      [`SSAC_DATA_W-1:0]   o_core_wdata,
	output logic                           o_asleep
);

	ssac_op_t                          op;
	ssac_pwr_t                         pwr;
	logic [`SSAC_ADDR_W-1:`SSAC_BURST_W] base;
	logic [`SSAC_BURST_W-1:0]          offset;
	logic [`SSAC_LANES-1:0]            next_lane_we;
	logic [`SSAC_LANES-1:0]            lane_sel_n;
	logic                              active;
	logic                              selected;
	logic                              proc_take;
	logic                              ctrl_take;
	logic                              strobe;
	logic                              write_req;
	logic                              begin_read;
	logic                              begin_write;
	logic                              deselect;
	logic                              burst;
	logic                              write_now;

	assign active   = (pwr == PWR_ACTIVE);
	assign selected = !i_chip_select_one_n && i_chip_select_two &&
		!i_chip_select_three_n;
	// processor strobe is ignored while select one is high
	assign proc_take = !i_processor_address_strobe_n && !i_chip_select_one_n;
	assign ctrl_take = !i_controller_address_strobe_n && !proc_take;
	assign strobe    = proc_take || ctrl_take;

	assign lane_sel_n[`SSAC_LANE_A] = i_lane_write_a_n;
	assign lane_sel_n[`SSAC_LANE_B] = i_lane_write_b_n;

	// per-lane write decode
	genvar g;
	generate
		for (g = 0; g < `SSAC_LANES; g = g + 1)
		begin : g_lane
			assign next_lane_we[g] = !i_global_write_n ||
				(!i_byte_write_gate_n && !lane_sel_n[g]);
		end
	endgenerate

	assign write_req = |next_lane_we;

	// a selected processor strobe always reads, whatever the write inputs say
	assign begin_read  = active && strobe && selected &&
		(proc_take || !write_req);
	assign begin_write = active && ctrl_take && selected &&
		write_req;
	assign deselect    = active && strobe && !selected;
	assign burst       = active && !strobe && (op != OP_IDLE);
	// a processor-strobe cycle itself never writes; the following edge may
	assign write_now   = begin_write || (burst && write_req);

	ssac_burst_ctr u_ssac_burst_ctr
	(
		.i_ref_clk    (i_ref_clk),
		.i_rst        (i_rst),
		.i_load       (begin_read || begin_write),
		.i_advance    (burst && !i_burst_advance_n),
		.i_burst_mode (i_burst_mode),
		.i_start      (i_addr[`SSAC_BURST_W-1:0]),
		.o_offset     (offset)
	);

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			base <= '0;
		else if (begin_read || begin_write)
			base <= i_addr[`SSAC_ADDR_W-1:`SSAC_BURST_W];
	end

	assign o_core_addr = {base, offset};

	// access state; leaving the active power state drops any burst
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst || !active || deselect)
			op <= OP_IDLE;
		else if (begin_read)
			op <= OP_READ;
		else if (write_now)
			op <= OP_WRITE;
	end

	// write strobes and data are registered, the core writes after the edge
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst || !write_now)
			o_core_lane_we <= `SSAC_NO_LANES;
		else
			o_core_lane_we <= next_lane_we;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			o_core_wdata <= '0;
		else if (write_now)
			o_core_wdata <= i_data_pins;
	end

	// one intermediate state each way gives the two-cycle sleep entry and exit
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			pwr <= PWR_ACTIVE;
		else
		begin
			case (pwr)
			PWR_ACTIVE:
				if (i_sleep_request)
					pwr <= PWR_ENTER;
			PWR_ENTER:
				pwr <= i_sleep_request ? PWR_ASLEEP : PWR_EXIT;
			PWR_ASLEEP:
				if (!i_sleep_request)
					pwr <= PWR_EXIT;
			PWR_EXIT:
				pwr <= i_sleep_request ? PWR_ENTER : PWR_ACTIVE;
			default:
				pwr <= PWR_ACTIVE;
			endcase
		end
	end

	assign o_asleep = (pwr == PWR_ASLEEP);

	// flow-through: the core answers the registered address without a stage;
	// the enable is not clocked, so pins follow output enable at once;
	// a write seen on the inputs masks the drivers before it lands
	assign o_data_pins    = i_core_rdata;
	assign o_data_pins_oe = (op == OP_READ) && active &&
		!write_now &&
		!i_output_enable_n;
	// a write cycle holds op at OP_WRITE, so the enable level no longer matters

	sequence s_sleep_in;
		(pwr == PWR_ACTIVE && i_sleep_request) ##1 i_sleep_request;
	endsequence

	sequence s_sleep_out;
		(pwr == PWR_ASLEEP && !i_sleep_request) ##1 !i_sleep_request;
	endsequence

	proc_read_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		(active && proc_take && selected) |=>
			(op == OP_READ && o_core_lane_we == `SSAC_NO_LANES))
		else $error("processor strobe did not start a plain read");

	write_gate_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		(!ctrl_take && (proc_take || op == OP_IDLE)) |=>
			(o_core_lane_we == `SSAC_NO_LANES))
		else $error("write taken outside an allowed cycle");

	write_mask_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		(op == OP_WRITE || write_now) |-> !o_data_pins_oe)
		else $error("data pins driven during a write");

	oe_low_drive_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		(op == OP_READ && active && !write_now && !i_output_enable_n) |->
			o_data_pins_oe)
		else $error("read data not driven with output enable low");

	oe_off_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		(i_output_enable_n || op == OP_IDLE) |-> !o_data_pins_oe)
		else $error("pins driven while disabled or deselected");

	lane_a_only_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		(write_now && i_global_write_n && !i_byte_write_gate_n &&
		 !i_lane_write_a_n && i_lane_write_b_n) |=>
			(o_core_lane_we == `SSAC_ONLY_LANE_A))
		else $error("lane a write touched another lane");

	lane_b_only_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		(write_now && i_global_write_n && !i_byte_write_gate_n &&
		 i_lane_write_a_n && !i_lane_write_b_n) |=>
			(o_core_lane_we == `SSAC_ONLY_LANE_B))
		else $error("lane b write touched another lane");

	global_write_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		(active && ctrl_take && selected && !i_global_write_n) |=>
			(o_core_lane_we == `SSAC_ALL_LANES && op == OP_WRITE))
		else $error("global write did not write all lanes");

	linear_step_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		(burst && !i_burst_advance_n && i_burst_mode == `SSAC_MODE_LINEAR &&
		 $stable(i_burst_mode)) |=>
			(offset == $past(offset) + `SSAC_BURST_ONE))
		else $error("linear burst did not step by one");

	suspend_hold_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		(burst && i_burst_advance_n) |=> $stable(o_core_addr))
		else $error("suspended burst moved its address");

	deselect_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		deselect |=> (op == OP_IDLE && o_core_lane_we == `SSAC_NO_LANES))
		else $error("unselected strobe did not deselect");

	sleep_enter_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		s_sleep_in |=> (pwr == PWR_ASLEEP && op == OP_IDLE))
		else $error("sleep not reached in two cycles");

	sleep_exit_a: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		s_sleep_out |=> (pwr == PWR_ACTIVE))
		else $error("sleep not left in two cycles");

endmodule

// ===== hdl/ssac_defines.svh
// Purpose: shared constants for the burst SRAM access control
// Assumes: by-18 organisation, two byte lanes of eight data bits plus parity
// Notes:   bit positions and codes are named here and nowhere else
`ifndef SSAC_DEFINES_SVH
`define SSAC_DEFINES_SVH

`define SSAC_ADDR_W        20
`define SSAC_BURST_W       2
`define SSAC_LANES         2
`define SSAC_LANE_W        9
`define SSAC_DATA_W        18
`define SSAC_LANE_A        0
`define SSAC_LANE_B        1
`define SSAC_NO_LANES      2'h0
`define SSAC_ALL_LANES     2'h3
`define SSAC_ONLY_LANE_A   2'h1
`define SSAC_ONLY_LANE_B   2'h2
`define SSAC_BURST_ZERO    2'h0
`define SSAC_BURST_ONE     2'h1
`define SSAC_MODE_LINEAR   1'h0

`endif

// ===== hdl/ssac_pkg.sv
// Purpose: types shared by the burst SRAM access control modules
// Assumes: nothing beyond the defines header
// Notes:   state encodings are left to the tools
package ssac_pkg;

	typedef enum logic [1:0]
	{
		OP_IDLE,
		OP_READ,
		OP_WRITE
	} ssac_op_t;

	typedef enum logic [1:0]
	{
		PWR_ACTIVE,
		PWR_ENTER,
		PWR_ASLEEP,
		PWR_EXIT
	} ssac_pwr_t;

endpackage

// ===== hdl/ssac_burst_ctr.sv
// Purpose: two-bit wrapping burst counter with interleaved or linear order
// Assumes: load and advance are never high together
// Notes:   the offset combines the start and count flops with the unregistered burst mode input
`timescale 1ns/1ps
`include "ssac_defines.svh"

module ssac_burst_ctr
	import ssac_pkg::*;
(
	// clock and reset
	input  wire logic                       i_ref_clk,
	input  wire logic                       i_rst,
	// control
	input  wire logic                       i_load,
	input  wire logic                       i_advance,
	input  wire logic                       i_burst_mode,
	input  wire logic [`SSAC_BURST_W-1:0]   i_start,
	// result
	output logic      [`SSAC_BURST_W-1:0]   o_offset
);

	logic [`SSAC_BURST_W-1:0] start;
	logic [`SSAC_BURST_W-1:0] count;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			start <= `SSAC_BURST_ZERO;
		else if (i_load)
			start <= i_start;
	end

	// count wraps within four locations on its own width
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst || i_load)
			count <= `SSAC_BURST_ZERO;
		else if (i_advance)
			count <= count + `SSAC_BURST_ONE;
	end

	assign o_offset = (i_burst_mode == `SSAC_MODE_LINEAR) ?
		start + count : start ^ count;

endmodule

// ===== bench/ssac_core_model.sv
// Purpose: memory core model behind the access control
// Assumes: combinational read, lane writes on the clock edge
// Notes:   only 16 words; upper address bits alias
`timescale 1ns/1ps

module ssac_core_model
(
	// clock
	input  wire logic        i_ref_clk,
	// core side
	input  wire logic [19:0] i_addr,
	input  wire logic [1:0]  i_lane_we,
	input  wire logic [17:0] i_wdata,
	output logic      [17:0] o_rdata
);
	// words never written read as unknown; scenarios read back only written ones
	logic [17:0] mem [16];

	assign o_rdata = mem[i_addr[3:0]];

	// each lane keeps its parity bit with its byte
	always_ff @(posedge i_ref_clk)
	begin
		if (i_lane_we[0])
			mem[i_addr[3:0]][8:0] <= i_wdata[8:0];
		if (i_lane_we[1])
			mem[i_addr[3:0]][17:9] <= i_wdata[17:9];
	end
endmodule

// ===== bench/test_ssac_ctrl.sv
// Purpose: self-checking bench for the access control
// Assumes: inputs change on the falling edge
// Notes:   latencies are the fixed ones of the hand-over
`timescale 1ns/1ps
`include "ssac_defines.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	err_total++; $display("unexpected %s exp %h got %h", n, e, g); end end

module test_ssac_ctrl;
	logic        clk = 0, rst = 1, cs1_n = 0, cs2 = 1, cs3_n = 0;
	logic        pas_n = 1, cas_n = 1, burst_n = 1, mode = 0, slp = 0;
	logic        glob_n = 1, gate_n = 1, la_n = 1, lb_n = 1, oe_n = 0;
	logic [19:0] addr = 20'h0;
	logic [17:0] din = 18'h0;
	logic [17:0] dout, rdata, wdata;
	logic [19:0] caddr;
	logic [1:0]  we;
	logic        oe, asleep;
	int          err_total = 0, cmp_count = 0;

	initial
	begin
		forever #10 clk = ~clk;
	end

	ssac_ctrl u_ssac_ctrl (.i_ref_clk(clk), .i_rst(rst),
		.i_chip_select_one_n(cs1_n), .i_chip_select_two(cs2),
		.i_chip_select_three_n(cs3_n),
		.i_processor_address_strobe_n(pas_n),
		.i_controller_address_strobe_n(cas_n),
		.i_burst_advance_n(burst_n), .i_burst_mode(mode),
		.i_sleep_request(slp), .i_global_write_n(glob_n),
		.i_byte_write_gate_n(gate_n), .i_lane_write_a_n(la_n),
		.i_lane_write_b_n(lb_n), .i_output_enable_n(oe_n),
		.i_addr(addr), .i_data_pins(din), .o_data_pins(dout),
		.o_data_pins_oe(oe), .i_core_rdata(rdata),
		.o_core_addr(caddr), .o_core_lane_we(we),
		.o_core_wdata(wdata), .o_asleep(asleep));

	ssac_core_model u_ssac_core_model (.i_ref_clk(clk), .i_addr(caddr),
		.i_lane_we(we), .i_wdata(wdata), .o_rdata(rdata));

	task step;
		@(negedge clk);
	endtask

	task t_read;
		pas_n = 0; glob_n = 0; addr = 20'h00005; step;
		pas_n = 1; glob_n = 1;
		`CHK("addr", 20'h00005, caddr)
		`CHK("we", 2'h0, we)
		`CHK("oe", 1'b1, oe)
		oe_n = 1; burst_n = 0; #1;
		`CHK("oe off", 1'b0, oe)
		step;
		`CHK("linear", 20'h00006, caddr)
		`CHK("oe held off", 1'b0, oe)
		oe_n = 0; burst_n = 1; #1;
		`CHK("oe on", 1'b1, oe)
		step;
		`CHK("suspend", 20'h00006, caddr)
		burst_n = 0; step; step;
		`CHK("wrap", 20'h00004, caddr)
		// burst order is only changed right after a new strobe
		burst_n = 1; pas_n = 0; step;
		mode = 1; pas_n = 1; burst_n = 0; step;
		`CHK("interleave", 20'h00004, caddr)
		burst_n = 1; mode = 0;
		$display("read test done");
	endtask

	task t_write;
		oe_n = 1;
		cas_n = 0; glob_n = 0; addr = 20'h00008; din = 18'h2a5a5; step;
		cas_n = 1; burst_n = 0; din = 18'h15a5a; oe_n = 0; #1;
		`CHK("we all", 2'h3, we)
		`CHK("wdata", 18'h2a5a5, wdata)
		`CHK("oe masked", 1'b0, oe)
		step;
		`CHK("we next", 2'h3, we)
		`CHK("addr next", 20'h00009, caddr)
		`CHK("wdata next", 18'h15a5a, wdata)
		glob_n = 1; burst_n = 1; pas_n = 0; step;
		pas_n = 1;
		`CHK("readback", 18'h2a5a5, dout)
		`CHK("read oe", 1'b1, oe)
		// pins are released in the same step as the master presents write data
		oe_n = 1; gate_n = 0; la_n = 0; din = 18'h3ffff;
		step;
		la_n = 1; lb_n = 0; din = 18'h0;
		`CHK("lane a", 2'h1, we)
		step;
		gate_n = 1; lb_n = 1;
		`CHK("lane b", 2'h2, we)
		step;
		`CHK("gate off", 2'h0, we)
		pas_n = 0; oe_n = 0; step;
		pas_n = 1;
		`CHK("merged", 18'h001ff, dout)
		`CHK("merged oe", 1'b1, oe)
		$display("write test done");
	endtask

	task t_desel;
		cas_n = 0; cs2 = 0; glob_n = 0; step;
		cas_n = 1; cs2 = 1;
		`CHK("desel oe", 1'b0, oe)
		// a burst beat with write inputs would write if the read survived
		step;
		glob_n = 1;
		`CHK("desel we", 2'h0, we)
		$display("deselect test done");
	endtask

	task t_sleep;
		// select one and both strobes stay inactive across both transitions
		cs1_n = 1; slp = 1; step;
		`CHK("entering", 1'b0, asleep)
		step;
		`CHK("asleep", 1'b1, asleep)
		`CHK("sleep oe", 1'b0, oe)
		slp = 0; step;
		`CHK("leaving", 1'b0, asleep)
		step;
		cs1_n = 0; pas_n = 0; addr = 20'h00009; step;
		pas_n = 1;
		`CHK("awake", 18'h15a5a, dout)
		`CHK("awake oe", 1'b1, oe)
		$display("sleep test done");
	endtask

	task give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		repeat (4) step;
		rst = 0;
		`CHK("reset we", 2'h0, we)
		`CHK("reset addr", 20'h0, caddr)
		`CHK("reset oe", 1'b0, oe)
		t_read;
		t_write;
		t_desel;
		t_sleep;
		give_verdict;
	end
endmodule
